//--- src/sbsr_params.svh
// Constants of the status byte and service request block
`ifndef SBSR_PARAMS_SVH
`define SBSR_PARAMS_SVH

// ---------------------------------------------------------------
// Status byte bit positions
// ---------------------------------------------------------------
`define SBSR_BIT_ZERO0 0
`define SBSR_BIT_ZERO1 1
`define SBSR_BIT_ERRQ 2
`define SBSR_BIT_QUES 3
`define SBSR_BIT_OUTQ 4
`define SBSR_BIT_STDEV 5
`define SBSR_BIT_MASTER 6
`define SBSR_BIT_OPER 7

// ---------------------------------------------------------------
// Enable mask reset value and summary care mask
// ---------------------------------------------------------------
`define SBSR_MASK_RESET 8'h00
`define SBSR_SUMMARY_CARE 8'hBC

`endif

//--- src/sbsr_pkg.sv
// Types of the status byte and service request block
package sbsr_pkg;
   typedef logic [7:0] sbsr_byte_t;
endpackage : sbsr_pkg

//--- src/sbsr_status_byte.sv
// Status byte and service request logic
`timescale 1ns/10ps
`include "sbsr_params.svh"

// Overview of operation
// - Status byte bits 0 and 1 always read zero.
// - Bit 2 set while the error queue is not empty.
// - Bit 3 follows the questionable group summary.
// - Bit 4 set while response data waits in output queue.
// - Bit 5 follows the standard event group summary.
// - Bit 7 follows the operation group summary.
// - Bit 6 is the master summary of enabled reasons.
// - Rising summary bit starts a request if enabled and none pending.
// - Request stays pending until the controller serial polls the status byte.
// - Starting a request raises bus request line and request bit.
// - Serial poll returns full byte then clears only the request bit.
// - Query reads bit 6 as master summary, poll reads request bit.
// - Query returns set bits without clearing any of them.
// - Eight-bit enable mask written by the enable command.
// - Mask query returns the value last written.
// - Enable mask presets to all zeros.
// - Clear-status forces summaries low for its cycle and is echoed on clear_status_o a cycle later.
module sbsr_status_byte (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic err_queue_nonempty_i,
   input wire logic ques_summary_i,
   input wire logic output_queue_ready_i,
   input wire logic std_event_summary_i,
   input wire logic oper_summary_i,
   input wire logic mask_wr_i,
   input wire logic [7:0] mask_wdata_i,
   input wire logic serial_poll_i,
   input wire logic clear_status_i,
   output logic [7:0] poll_byte_o,
   output logic [7:0] query_byte_o,
   output logic [7:0] mask_rdata_o,
   output logic srq_o,
   output logic clear_status_o
);

   // ------------------------------------------------------------
   // Bit positions
   // ------------------------------------------------------------
   localparam int BIT_ZERO0 = `SBSR_BIT_ZERO0;
   localparam int BIT_ZERO1 = `SBSR_BIT_ZERO1;
   localparam int BIT_ERRQ = `SBSR_BIT_ERRQ;
   localparam int BIT_QUES = `SBSR_BIT_QUES;
   localparam int BIT_OUTQ = `SBSR_BIT_OUTQ;
   localparam int BIT_STDEV = `SBSR_BIT_STDEV;
   localparam int BIT_MASTER = `SBSR_BIT_MASTER;
   localparam int BIT_OPER = `SBSR_BIT_OPER;
   localparam sbsr_pkg::sbsr_byte_t CARE = `SBSR_SUMMARY_CARE;
   localparam sbsr_pkg::sbsr_byte_t MASK_RESET = `SBSR_MASK_RESET;

   // ------------------------------------------------------------
   // Position table
   // ------------------------------------------------------------
   localparam int POSITIONS [8] = '{
      BIT_ZERO0,
      BIT_ZERO1,
      BIT_ERRQ,
      BIT_QUES,
      BIT_OUTQ,
      BIT_STDEV,
      BIT_MASTER,
      BIT_OPER
   };

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   for (genvar i = 0; i < 8; i++) begin : g_chk_pos
      if (POSITIONS[i] < 0 || POSITIONS[i] > 7) begin : g_range
         $error("status byte position outside the byte");
      end
      for (genvar j = i + 1; j < 8; j++) begin : g_unique
         if (POSITIONS[i] == POSITIONS[j]) begin : g_clash
            $error("two status byte positions coincide");
         end
      end
   end

   if (CARE[BIT_MASTER] != 1'b0) begin : g_chk_master
      $error("master summary position must not be a summary input");
   end

   if (CARE[BIT_ZERO0] != 1'b0) begin : g_chk_zero0
      $error("reserved position zero must stay out of the summary");
   end

   if (CARE[BIT_ZERO1] != 1'b0) begin : g_chk_zero1
      $error("reserved position one must stay out of the summary");
   end

   if (CARE[BIT_ERRQ] != 1'b1) begin : g_chk_errq
      $error("error queue position missing from the summary");
   end

   if (CARE[BIT_QUES] != 1'b1) begin : g_chk_ques
      $error("questionable position missing from the summary");
   end

   if (CARE[BIT_OUTQ] != 1'b1) begin : g_chk_outq
      $error("output queue position missing from the summary");
   end

   if (CARE[BIT_STDEV] != 1'b1) begin : g_chk_stdev
      $error("standard event position missing from the summary");
   end

   if (CARE[BIT_OPER] != 1'b1) begin : g_chk_oper
      $error("operation position missing from the summary");
   end

   if (MASK_RESET != 8'h00) begin : g_chk_reset
      $error("enable mask must preset to zero");
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   sbsr_pkg::sbsr_byte_t mask_ff;
   sbsr_pkg::sbsr_byte_t poll_byte_ff;
   sbsr_pkg::sbsr_byte_t query_byte_ff;
   logic request_service_bit_ff;
   logic clear_status_ff;

   // ------------------------------------------------------------
   // Next values
   // ------------------------------------------------------------
   sbsr_pkg::sbsr_byte_t nxt_mask;
   sbsr_pkg::sbsr_byte_t nxt_poll_byte;
   sbsr_pkg::sbsr_byte_t nxt_query_byte;
   logic nxt_request_service_bit;
   logic nxt_clear_status;

   // ------------------------------------------------------------
   // Input and strobe wires
   // ------------------------------------------------------------
   wire logic err_bit;
   wire logic ques_bit;
   wire logic outq_bit;
   wire logic stdev_bit;
   wire logic oper_bit;
   wire logic clear_now;
   wire logic mask_load;
   wire logic poll_now;

   // ------------------------------------------------------------
   // Byte and decision wires
   // ------------------------------------------------------------
   wire sbsr_pkg::sbsr_byte_t summary_raw;
   wire sbsr_pkg::sbsr_byte_t summary_now;
   wire sbsr_pkg::sbsr_byte_t rising;
   wire sbsr_pkg::sbsr_byte_t enabled_rise;
   wire sbsr_pkg::sbsr_byte_t enabled_level;
   wire sbsr_pkg::sbsr_byte_t query_byte;
   wire sbsr_pkg::sbsr_byte_t poll_byte;
   wire logic master_summary_bit;
   wire logic any_enabled_rise;
   wire logic request_pending;
   wire logic start_request;
   wire logic clear_request;

   // ------------------------------------------------------------
   // Inputs
   // ------------------------------------------------------------
   assign err_bit = err_queue_nonempty_i;
   assign ques_bit = ques_summary_i;
   assign outq_bit = output_queue_ready_i;
   assign stdev_bit = std_event_summary_i;
   assign oper_bit = oper_summary_i;
   assign clear_now = clear_status_i;
   assign mask_load = mask_wr_i;
   assign poll_now = serial_poll_i;

   // ------------------------------------------------------------
   // Status byte assembly
   // ------------------------------------------------------------
   assign summary_raw[BIT_ZERO0] = 1'b0;
   assign summary_raw[BIT_ZERO1] = 1'b0;
   assign summary_raw[BIT_ERRQ] = err_bit;
   assign summary_raw[BIT_QUES] = ques_bit;
   assign summary_raw[BIT_OUTQ] = outq_bit;
   assign summary_raw[BIT_STDEV] = stdev_bit;
   assign summary_raw[BIT_MASTER] = 1'b0;
   assign summary_raw[BIT_OPER] = oper_bit;

   // ------------------------------------------------------------
   // Clear-status gating
   // ------------------------------------------------------------
   // Clear-status forces summaries low for its cycle
   assign summary_now = clear_now ? 8'h00 : (summary_raw & CARE);

   // ------------------------------------------------------------
   // Per-bit edge detection and selection
   // ------------------------------------------------------------
   for (genvar b = 0; b < 8; b++) begin : g_bit
      localparam bit IS_MASTER = (b == BIT_MASTER);
      localparam bit BIT_CARE = CARE[b];
      logic bit_prev_ff;
      wire logic bit_now;
      wire logic bit_mask;
      wire logic bit_rise;
      wire logic bit_armed;

      assign bit_now = summary_now[b];
      assign bit_mask = mask_ff[b];
      assign bit_rise = bit_now & ~bit_prev_ff;
      assign bit_armed = bit_mask & BIT_CARE;

      always_ff @(posedge clk_i) begin
         if (sys_rst_i) begin
            bit_prev_ff <= 1'b0;
         end else begin
            bit_prev_ff <= bit_now;
         end
      end

      assign rising[b] = bit_rise;
      assign enabled_rise[b] = bit_rise & bit_armed;
      assign enabled_level[b] = bit_now & bit_armed;
      assign query_byte[b] = IS_MASTER ? master_summary_bit :
                             bit_now;
      assign poll_byte[b] = IS_MASTER ? request_service_bit_ff :
                            bit_now;
   end

   // ------------------------------------------------------------
   // Request decision
   // ------------------------------------------------------------
   assign master_summary_bit = |enabled_level;
   assign any_enabled_rise = |enabled_rise;
   assign request_pending = request_service_bit_ff;
   assign start_request = any_enabled_rise & ~request_pending;
   assign clear_request = poll_now & ~start_request;

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      nxt_mask = mask_ff;
      if (mask_load) begin
         nxt_mask = mask_wdata_i;
      end
   end

   always_comb begin
      nxt_request_service_bit = request_service_bit_ff;
      if (clear_request) begin
         nxt_request_service_bit = 1'b0;
      end
      if (start_request) begin
         nxt_request_service_bit = 1'b1;
      end
   end

   always_comb begin
      nxt_poll_byte = poll_byte_ff;
      if (poll_now) begin
         nxt_poll_byte = poll_byte;
      end
   end

   always_comb begin
      nxt_query_byte = query_byte;
   end

   always_comb begin
      nxt_clear_status = clear_now;
   end

   // ------------------------------------------------------------
   // Enable mask register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mask_ff <= MASK_RESET;
      end else begin
         mask_ff <= nxt_mask;
      end
   end

   // ------------------------------------------------------------
   // Request bit register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         request_service_bit_ff <= 1'b0;
      end else begin
         request_service_bit_ff <= nxt_request_service_bit;
      end
   end

   // ------------------------------------------------------------
   // Poll byte register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         poll_byte_ff <= 8'h00;
      end else begin
         poll_byte_ff <= nxt_poll_byte;
      end
   end

   // ------------------------------------------------------------
   // Query byte register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         query_byte_ff <= 8'h00;
      end else begin
         query_byte_ff <= nxt_query_byte;
      end
   end

   // ------------------------------------------------------------
   // Clear-status pulse register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         clear_status_ff <= 1'b0;
      end else begin
         clear_status_ff <= nxt_clear_status;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign poll_byte_o = poll_byte_ff;
   assign query_byte_o = query_byte_ff;
   assign mask_rdata_o = mask_ff;
   assign srq_o = request_service_bit_ff;
   assign clear_status_o = clear_status_ff;

endmodule : sbsr_status_byte

//--- tb/sbsr_checker.sv
// Assertions on the ports of the status byte block
`timescale 1ns/10ps
module sbsr_checker (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic err_queue_nonempty_i,
   input wire logic ques_summary_i,
   input wire logic output_queue_ready_i,
   input wire logic std_event_summary_i,
   input wire logic oper_summary_i,
   input wire logic mask_wr_i,
   input wire logic serial_poll_i,
   input wire logic clear_status_i,
   input wire logic [7:0] mask_wdata_i,
   input wire logic [7:0] poll_byte_o,
   input wire logic [7:0] query_byte_o,
   input wire logic [7:0] mask_rdata_o,
   input wire logic srq_o,
   input wire logic clear_status_o
);
   logic [7:0] sum;
   logic [7:0] prev_ff;
   logic [7:0] rise;
   assign sum = {oper_summary_i, 1'b0, std_event_summary_i,
      output_queue_ready_i, ques_summary_i, err_queue_nonempty_i, 2'b00};
   assign rise = sum & ~prev_ff & mask_rdata_o & {8{!clear_status_i}};
   always_ff @(posedge clk_i)
      prev_ff <= (sys_rst_i | clear_status_i) ? 8'h00 : sum;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_zero_bits: assert property (
      query_byte_o[1:0] == 2'b00 && poll_byte_o[1:0] == 2'b00)
      else $error("low bits not zero");
   a_summary_bits: assert property (
      (query_byte_o & 8'hbc) == prev_ff)
      else $error("summary bits wrong");
   a_master_bit: assert property (
      query_byte_o[6] == |(prev_ff & $past(mask_rdata_o)))
      else $error("master summary wrong");
   a_start_req: assert property (
      rise != 0 && !srq_o |=> srq_o)
      else $error("request not started");
   a_no_cause: assert property (
      !srq_o && rise == 0 |=> !srq_o)
      else $error("request without cause");
   a_req_holds: assert property (
      srq_o && !serial_poll_i |=> srq_o)
      else $error("request dropped");
   a_poll_clear: assert property (
      serial_poll_i && rise == 0 |=> !srq_o)
      else $error("poll left request");
   a_poll_value: assert property (
      serial_poll_i |=> poll_byte_o[6] == $past(srq_o))
      else $error("poll bit 6 wrong");
   a_clear_echo: assert property (
      clear_status_i |=> clear_status_o)
      else $error("clear not passed on");
   a_mask_write: assert property (
      mask_wr_i |=> mask_rdata_o == $past(mask_wdata_i))
      else $error("mask not written");
   a_reset_state: assert property (
      disable iff (1'b0) sys_rst_i |=> mask_rdata_o == 8'h00 && !srq_o)
      else $error("reset state wrong");
   cover property (rise != 0 && !srq_o);
   cover property (serial_poll_i && srq_o);
   cover property (mask_wr_i);
endmodule : sbsr_checker
bind sbsr_status_byte sbsr_checker u_chk (.*);

//--- tb/sbsr_ctl_model.sv
// Bus controller that polls when the request line is up
`timescale 1ns/10ps
module sbsr_ctl_model (
   input wire logic clk_i,
   input wire logic en_i,
   input wire logic srq_i,
   output logic poll_o
);
   initial poll_o = 1'b0;
   always @(negedge clk_i) poll_o <= en_i && srq_i && !poll_o;
endmodule : sbsr_ctl_model

//--- tb/sbsr_status_byte_bench.sv
// Self-checking bench of the status byte block
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
   fails++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module sbsr_status_byte_bench;
   logic clk_i = 0, sys_rst_i = 1, mask_wr_i = 0, clr = 0, tb_poll = 0, en = 0;
   logic [4:0] st = 0;
   logic [7:0] wd = 0;
   wire logic poll, srq, clr_o, ctl_p;
   wire logic [7:0] pb, qb, mr;
   int fails = 0, samples_checked = 0;
   logic [23:0] rows [8] = '{24'h1f_40bc, 24'h01_4444, 24'h02_4848,
      24'h04_5050, 24'h08_6060, 24'h10_c0c0, 24'h10_4080, 24'h1f_43bc};
   sbsr_status_byte u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .err_queue_nonempty_i(st[0]), .ques_summary_i(st[1]),
      .output_queue_ready_i(st[2]), .std_event_summary_i(st[3]),
      .oper_summary_i(st[4]), .mask_wr_i(mask_wr_i), .mask_wdata_i(wd),
      .serial_poll_i(poll), .clear_status_i(clr), .poll_byte_o(pb),
      .query_byte_o(qb), .mask_rdata_o(mr), .srq_o(srq),
      .clear_status_o(clr_o));
   sbsr_ctl_model u_ctl (.clk_i(clk_i), .en_i(en), .srq_i(srq),
      .poll_o(ctl_p));
   assign poll = tb_poll | ctl_p;
   always #2 clk_i = ~clk_i;
   task automatic step(input int n);
      repeat (n) @(negedge clk_i);
   endtask : step
   task automatic set_mask(input logic [7:0] m);
      wd = m;
      mask_wr_i = 1;
      step(1);
      mask_wr_i = 0;
   endtask : set_mask
   task automatic do_poll;
      tb_poll = 1;
      step(1);
      tb_poll = 0;
   endtask : do_poll
   task automatic close_out;
      $display("checked %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out
   initial begin
      #20000;
      fails++;
      close_out;
   end
   initial begin
      step(16);
      sys_rst_i = 0;
      `CHK("mask", 8'h00, mr)
      `CHK("srq", 1'b0, srq)
      $display("reset test done");
      foreach (rows[i]) begin
         st = 0;
         set_mask(rows[i][15:8]);
         st = rows[i][20:16];
         step(2);
         `CHK("query", rows[i][7:0], qb)
         `CHK("mask", rows[i][15:8], mr)
      end
      $display("table test done");
      do_poll;
      st = 0;
      set_mask(8'hc8);
      st = 5'h02;
      step(1);
      `CHK("srq", 1'b1, srq)
      st = 5'h12;
      step(1);
      do_poll;
      `CHK("poll", 8'hc8, pb)
      `CHK("srq", 1'b0, srq)
      `CHK("query", 8'hc8, qb)
      do_poll;
      `CHK("poll", 8'h88, pb)
      $display("poll test done");
      en = 1;
      st = 0;
      step(2);
      st = 5'h10;
      for (int k = 0; k < 10 && pb !== 8'hc0; k++) step(1);
      `CHK("model poll", 8'hc0, pb)
      `CHK("srq", 1'b0, srq)
      en = 0;
      clr = 1;
      step(1);
      clr = 0;
      `CHK("clear", 1'b1, clr_o)
      `CHK("query after clear", 8'h00, qb)
      $display("model and clear tests done");
      close_out;
   end
endmodule : sbsr_status_byte_bench
